//--- src/awk_pkg.sv
/*
 * Constants, types and register map of the auto wake-up from halt timer.
 * Assumes a single 50 MHz system clock and an AXI4-Lite register bus.
 */
package awk_pkg;
    localparam int AWK_ADDR_W = 12;
    localparam logic [7:0] AWK_CSR_IDX = 8'h48;
    localparam logic [7:0] AWK_PRE_IDX = 8'h49;
    localparam logic [7:0] AWK_CSR_RST = 8'h00;
    localparam logic [7:0] AWK_PRE_RST = 8'hFF;
    localparam logic [7:0] AWK_PRE_BAD = 8'h00;
    localparam int AWK_EN_BIT = 0;
    localparam int AWK_MEAS_BIT = 1;
    localparam int AWK_FLAG_BIT = 2;
    localparam int AWK_DIV_W = 6;
    localparam logic [5:0] AWK_DIV_LAST = 6'h3F;
    localparam int AWK_STAB_W = 9;
    localparam logic [8:0] AWK_STAB_LAST = 9'h0FF;
    localparam logic [1:0] AWK_OKAY = 2'h0;
    localparam logic [1:0] AWK_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        AWK_RUN,
        AWK_AWU_HALT,
        AWK_PLAIN_HALT,
        AWK_STAB
    } awk_mode_e;

    typedef struct packed {
        logic awvalid;
        logic [AWK_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AWK_ADDR_W-1:0] araddr;
        logic rready;
    } awk_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } awk_axi_rsp_s;

    typedef struct packed {
        awk_mode_e mode;
        logic wake_enable_bit;
        logic rc_measure_bit;
        logic wake_flag;
        logic [7:0] wake_prescaler;
        logic [AWK_DIV_W-1:0] div;
        logic [7:0] pcnt;
        logic [AWK_STAB_W-1:0] stab;
        logic woke_by_timer;
        logic aw_got;
        logic [AWK_ADDR_W-1:0] awaddr;
        logic w_got;
        logic [7:0] wdata;
        logic wlane0;
        awk_axi_rsp_s rsp;
        logic main_osc_en;
        logic cpu_hold;
        logic halted;
        logic awu_mode;
        logic irq;
        logic imask_clr;
        logic rc_osc_en;
        logic rc_capture;
        logic wdg_reset;
        logic resume;
        logic resume_timer;
    } awk_state_s;
endpackage : awk_pkg

//--- src/awk_wake_timer.sv
/*
 * Auto wake-up from halt timer: halt sequencing, RC tick divider and
 * prescaler, stabilisation delay, measurement routing, AXI4-Lite registers.
 * Assumes rc_tick_i is a one-cycle pulse per RC oscillator period, already
 * synchronous to mclk_i, and that the core drives halt_exec_i for one cycle.
 */
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Halt with enable set enters auto-wake halt
// - Auto-wake halt entry starts RC, divider, prescaler
// - Delay expiry sets flag and raises interrupt
// - Wake: oscillator on, hold 256 cycles
// - Then resume via auto-wake vector
// - Status read clears flag and interrupt
// - Writes never change the flag
// - Measure bit routes RC to capture while running
// - Measure bit also starts RC oscillator
// - Other halt-exit interrupt or reset wakes
// - Halt entry clears interrupt mask bit
// - Halt stops main oscillator and peripherals
// - Watchdog-in-halt option decides watchdog reset
// - Status resets to zero, bits 7:3 zero
// - Enable bit freely written by software
// - Prescaler N divides by N, 1..255
// - Writing zero to prescaler is ignored
// - Prescaler resets to FFh
// - Halt time is 64 times N RC periods
module awk_wake_timer (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire awk_pkg::awk_axi_req_s axi_req_i,
    output awk_pkg::awk_axi_rsp_s axi_rsp_o,
    input wire logic halt_exec_i,
    input wire logic halt_exit_irq_i,
    input wire logic watchdog_en_i,
    input wire logic watchdog_in_halt_option_i,
    input wire logic rc_tick_i,
    output logic main_osc_en_o,
    output logic cpu_hold_o,
    output logic halted_o,
    output logic auto_wake_halt_mode_o,
    output logic wake_irq_o,
    output logic imask_clear_o,
    output logic rc_osc_en_o,
    output logic rc_capture_o,
    output logic watchdog_reset_o,
    output logic resume_o,
    output logic resume_wake_vector_o
);
    import awk_pkg::*;

    awk_state_s st;
    awk_state_s next_st;
    logic wr_fire;
    logic rd_fire;
    logic expire;
    logic csr_read;

    function automatic logic addr_hit(input logic [AWK_ADDR_W-1:0] a,
                                      input logic [7:0] idx);
        addr_hit = (a[AWK_ADDR_W-1:2] == {2'h0, idx});
    endfunction : addr_hit

    assign wr_fire = st.aw_got && st.w_got && !st.rsp.bvalid;
    assign rd_fire = axi_req_i.arvalid && st.rsp.arready;
    assign csr_read = rd_fire && addr_hit(axi_req_i.araddr, AWK_CSR_IDX);
    assign expire = (st.mode == AWK_AWU_HALT) && rc_tick_i
        && (st.div == AWK_DIV_LAST)
        && (st.pcnt == st.wake_prescaler - 8'h01);

    always_comb begin
        next_st = st;
        next_st.imask_clr = 1'b0;
        next_st.wdg_reset = 1'b0;
        next_st.resume = 1'b0;
        next_st.resume_timer = 1'b0;

        // Write address and data taken in either order
        if (axi_req_i.awvalid && st.rsp.awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && st.rsp.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = axi_req_i.wdata[7:0];
            next_st.wlane0 = axi_req_i.wstrb[0];
        end
        if (st.rsp.bvalid && axi_req_i.bready) begin
            next_st.rsp.bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp = AWK_OKAY;
            if (addr_hit(st.awaddr, AWK_CSR_IDX)) begin
                if (st.wlane0) begin
                    next_st.wake_enable_bit = st.wdata[AWK_EN_BIT];
                    next_st.rc_measure_bit = st.wdata[AWK_MEAS_BIT];
                end
            end else if (addr_hit(st.awaddr, AWK_PRE_IDX)) begin
                if (st.wlane0 && st.wdata != AWK_PRE_BAD) begin
                    next_st.wake_prescaler = st.wdata;
                end
            end else begin
                next_st.rsp.bresp = AWK_SLVERR;
            end
        end

        if (st.rsp.rvalid && axi_req_i.rready) begin
            next_st.rsp.rvalid = 1'b0;
        end
        if (rd_fire) begin
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rresp = AWK_OKAY;
            next_st.rsp.rdata = 32'h0;
            if (addr_hit(axi_req_i.araddr, AWK_CSR_IDX)) begin
                next_st.rsp.rdata[AWK_FLAG_BIT] = st.wake_flag;
                next_st.rsp.rdata[AWK_MEAS_BIT] = st.rc_measure_bit;
                next_st.rsp.rdata[AWK_EN_BIT] = st.wake_enable_bit;
            end else if (addr_hit(axi_req_i.araddr, AWK_PRE_IDX)) begin
                next_st.rsp.rdata[7:0] = st.wake_prescaler;
            end else begin
                next_st.rsp.rresp = AWK_SLVERR;
            end
        end
        if (csr_read) begin
            next_st.wake_flag = 1'b0;
        end

        case (st.mode)
            AWK_RUN: begin
                if (halt_exec_i) begin
                    if (watchdog_en_i && !watchdog_in_halt_option_i) begin
                        next_st.wdg_reset = 1'b1;
                    end else begin
                        next_st.imask_clr = 1'b1;
                        next_st.div = '0;
                        next_st.pcnt = 8'h00;
                        if (st.wake_enable_bit) begin
                            next_st.mode = AWK_AWU_HALT;
                        end else begin
                            next_st.mode = AWK_PLAIN_HALT;
                        end
                    end
                end
            end
            AWK_AWU_HALT: begin
                if (expire) begin
                    next_st.wake_flag = 1'b1;
                    next_st.woke_by_timer = 1'b1;
                    next_st.stab = '0;
                    next_st.mode = AWK_STAB;
                end else if (halt_exit_irq_i) begin
                    next_st.woke_by_timer = 1'b0;
                    next_st.stab = '0;
                    next_st.mode = AWK_STAB;
                end else if (rc_tick_i) begin
                    next_st.div = st.div + 6'h01;
                    if (st.div == AWK_DIV_LAST) begin
                        next_st.pcnt = st.pcnt + 8'h01;
                    end
                end
            end
            AWK_PLAIN_HALT: begin
                if (halt_exit_irq_i) begin
                    next_st.woke_by_timer = 1'b0;
                    next_st.stab = '0;
                    next_st.mode = AWK_STAB;
                end
            end
            AWK_STAB: begin
                if (st.stab == AWK_STAB_LAST) begin
                    next_st.mode = AWK_RUN;
                    next_st.resume = 1'b1;
                    next_st.resume_timer = st.woke_by_timer;
                end else begin
                    next_st.stab = st.stab + 9'h001;
                end
            end
            default: begin
                next_st.mode = AWK_RUN;
            end
        endcase

        next_st.halted = (next_st.mode == AWK_AWU_HALT)
            || (next_st.mode == AWK_PLAIN_HALT);
        next_st.main_osc_en = !next_st.halted;
        next_st.cpu_hold = (next_st.mode != AWK_RUN);
        next_st.awu_mode = (next_st.mode == AWK_AWU_HALT);
        next_st.irq = next_st.wake_flag;
        next_st.rc_osc_en = next_st.rc_measure_bit
            || (next_st.mode == AWK_AWU_HALT);
        next_st.rc_capture = next_st.rc_measure_bit
            && (next_st.mode == AWK_RUN);
        next_st.rsp.awready = !next_st.aw_got && !next_st.rsp.bvalid;
        next_st.rsp.wready = !next_st.w_got && !next_st.rsp.bvalid;
        next_st.rsp.arready = !next_st.rsp.rvalid;
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st <= '0;
            st.mode <= AWK_RUN;
            st.wake_prescaler <= AWK_PRE_RST;
            st.main_osc_en <= 1'b1;
            st.rsp.awready <= 1'b1;
            st.rsp.wready <= 1'b1;
            st.rsp.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign axi_rsp_o = st.rsp;
    assign main_osc_en_o = st.main_osc_en;
    assign cpu_hold_o = st.cpu_hold;
    assign halted_o = st.halted;
    assign auto_wake_halt_mode_o = st.awu_mode;
    assign wake_irq_o = st.irq;
    assign imask_clear_o = st.imask_clr;
    assign rc_osc_en_o = st.rc_osc_en;
    assign rc_capture_o = st.rc_capture;
    assign watchdog_reset_o = st.wdg_reset;
    assign resume_o = st.resume;
    assign resume_wake_vector_o = st.resume_timer;

    default clocking dc @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    enter_awu_a: assert property (
        (st.mode == AWK_RUN) && halt_exec_i && st.wake_enable_bit
        && !(watchdog_en_i && !watchdog_in_halt_option_i)
        |=> (st.mode == AWK_AWU_HALT) && imask_clear_o
            && st.div == '0 && st.pcnt == 8'h00)
        else $error("auto-wake halt entry wrong");
    expire_flag_a: assert property (
        expire |=> st.wake_flag && (st.mode == AWK_STAB) && wake_irq_o)
        else $error("expiry did not set flag");
    stab_len_a: assert property (
        $fell(st.mode == AWK_STAB) |-> $past(st.stab) == AWK_STAB_LAST
            && resume_o)
        else $error("stabilisation length wrong");
    resume_vec_a: assert property (
        resume_wake_vector_o |-> resume_o && $past(st.woke_by_timer))
        else $error("wake vector without timer wake");
    read_clear_a: assert property (
        csr_read && !expire |=> !st.wake_flag && !wake_irq_o)
        else $error("status read did not clear flag");
    flag_write_a: assert property (
        wr_fire && !expire && !csr_read |=> $stable(st.wake_flag))
        else $error("write changed the flag");
    measure_route_a: assert property (
        rc_capture_o |-> rc_osc_en_o && st.rc_measure_bit)
        else $error("capture route without oscillator");
    irq_exit_a: assert property (
        (st.mode == AWK_AWU_HALT) && halt_exit_irq_i
        |=> (st.mode == AWK_STAB) ##1 cpu_hold_o && main_osc_en_o)
        else $error("halt-exit interrupt ignored");
    halt_osc_a: assert property (
        halted_o |-> !main_osc_en_o && cpu_hold_o)
        else $error("main oscillator on in halt");
    wdg_halt_a: assert property (
        (st.mode == AWK_RUN) && halt_exec_i && watchdog_en_i
        && !watchdog_in_halt_option_i |=> watchdog_reset_o && !halted_o)
        else $error("watchdog halt option ignored");
    presc_zero_a: assert property (
        wr_fire && addr_hit(st.awaddr, AWK_PRE_IDX)
        && st.wdata == AWK_PRE_BAD |=> $stable(st.wake_prescaler))
        else $error("zero prescaler write took effect");
    presc_valid_a: assert property (
        st.wake_prescaler != AWK_PRE_BAD)
        else $error("prescaler holds zero");

    // Halt entry and sequencing
    plain_enter_a: assert property (
        (st.mode == AWK_RUN) && halt_exec_i && !st.wake_enable_bit
        && !(watchdog_en_i && !watchdog_in_halt_option_i)
        |=> (st.mode == AWK_PLAIN_HALT) && halted_o
            && !auto_wake_halt_mode_o && imask_clear_o)
        else $error("plain halt entry wrong");
    rc_start_a: assert property (
        (st.mode == AWK_AWU_HALT) |-> rc_osc_en_o && auto_wake_halt_mode_o)
        else $error("RC oscillator off in auto-wake halt");
    div_step_a: assert property (
        (st.mode == AWK_AWU_HALT) && rc_tick_i && !expire
        && !halt_exit_irq_i |=> st.div == $past(st.div) + 6'h01)
        else $error("divider did not advance");
    presc_step_a: assert property (
        (st.mode == AWK_AWU_HALT) && rc_tick_i && !expire
        && !halt_exit_irq_i && (st.div == AWK_DIV_LAST)
        |=> st.pcnt == $past(st.pcnt) + 8'h01)
        else $error("prescaler count did not advance");
    tick_only_a: assert property (
        (st.mode == AWK_AWU_HALT) && !rc_tick_i && !halt_exit_irq_i
        |=> $stable(st.div) && $stable(st.pcnt)
            && (st.mode == AWK_AWU_HALT))
        else $error("halt count moved without RC tick");
    wake_osc_a: assert property (
        (st.mode == AWK_STAB) |-> main_osc_en_o && cpu_hold_o && !halted_o)
        else $error("stabilisation without main oscillator");
    stab_step_a: assert property (
        (st.mode == AWK_STAB) && (st.stab != AWK_STAB_LAST)
        |=> (st.mode == AWK_STAB) && st.stab == $past(st.stab) + 9'h001)
        else $error("stabilisation count wrong");
    resume_pulse_a: assert property (
        resume_o |-> !cpu_hold_o && (st.mode == AWK_RUN) ##1 !resume_o)
        else $error("resume pulse wrong");
    timer_mark_a: assert property (
        expire |=> st.woke_by_timer)
        else $error("timer wake not recorded");
    irq_source_a: assert property (
        $rose(wake_irq_o) |-> $past(expire))
        else $error("wake interrupt without expiry");

    // Register checks
    reg_reset_a: assert property (
        $fell(reset_i) |-> (st.wake_prescaler == AWK_PRE_RST)
            && !st.wake_flag && !st.rc_measure_bit && !st.wake_enable_bit)
        else $error("register reset values wrong");
    rsvd_zero_a: assert property (
        csr_read |=> axi_rsp_o.rdata[31:3] == 29'h0)
        else $error("reserved status bits not zero");
    en_write_a: assert property (
        wr_fire && addr_hit(st.awaddr, AWK_CSR_IDX) && st.wlane0
        |=> st.wake_enable_bit == $past(st.wdata[AWK_EN_BIT])
            && st.rc_measure_bit == $past(st.wdata[AWK_MEAS_BIT]))
        else $error("status write not applied");
    presc_write_a: assert property (
        wr_fire && addr_hit(st.awaddr, AWK_PRE_IDX) && st.wlane0
        && st.wdata != AWK_PRE_BAD |=> st.wake_prescaler == $past(st.wdata))
        else $error("prescaler write not applied");
    measure_osc_a: assert property (
        st.rc_measure_bit |-> rc_osc_en_o)
        else $error("measure bit left RC oscillator off");
    capture_run_a: assert property (
        rc_capture_o |-> (st.mode == AWK_RUN))
        else $error("capture routed outside run");

    // Halt exits, options and bus answer timing
    imask_entry_a: assert property (
        imask_clear_o |-> $past(halt_exec_i) && $past(st.mode == AWK_RUN))
        else $error("mask cleared outside halt entry");
    pending_wake_a: assert property (
        halted_o && halt_exit_irq_i |=> !halted_o && (st.mode == AWK_STAB))
        else $error("pending interrupt did not wake");
    plain_stay_a: assert property (
        (st.mode == AWK_PLAIN_HALT) && !halt_exit_irq_i
        |=> (st.mode == AWK_PLAIN_HALT))
        else $error("plain halt left without interrupt");
    halt_refuse_a: assert property (
        (st.mode == AWK_STAB) && halt_exec_i && (st.stab != AWK_STAB_LAST)
        |=> (st.mode == AWK_STAB))
        else $error("halt taken during stabilisation");
    wdg_cause_a: assert property (
        watchdog_reset_o |-> $past(halt_exec_i) && $past(watchdog_en_i)
            && !$past(watchdog_in_halt_option_i))
        else $error("watchdog reset without cause");
    bus_write_a: assert property (
        wr_fire |=> axi_rsp_o.bvalid)
        else $error("write answer late");
    bus_read_a: assert property (
        rd_fire |=> axi_rsp_o.rvalid)
        else $error("read answer late");

    timer_wake_c: cover property (expire ##[1:300] resume_wake_vector_o);
    irq_wake_c: cover property (
        (st.mode == AWK_PLAIN_HALT) && halt_exit_irq_i);
    measure_c: cover property (rc_capture_o ##1 csr_read);
    wdg_reset_c: cover property (watchdog_reset_o);
    pending_wake_c: cover property (imask_clear_o && halt_exit_irq_i);
endmodule : awk_wake_timer

`default_nettype wire

//--- bench/awk_rc_model.sv
/*
 * Stand-in for the wake-up RC oscillator: one tick pulse per period.
 * Assumes en_i is the design's RC enable; ticks start after a start-up.
 */
`timescale 1ns/10ps
`default_nettype none
module awk_rc_model #(
    parameter int START_CYC = 7,
    parameter int PERIOD_CYC = 3
) (
    input wire logic mclk_i,
    input wire logic en_i,
    output logic tick_o
);
    int cnt = 0;

    initial tick_o = 1'b0;

    // Idle while disabled, then start-up time before the first tick
    always @(posedge mclk_i) begin
        if (!en_i) begin
            cnt <= 0;
            tick_o <= 1'b0;
        end else begin
            cnt <= cnt + 1;
            tick_o <= (cnt >= START_CYC) &&
                ((cnt - START_CYC) % PERIOD_CYC == PERIOD_CYC - 1);
        end
    end
endmodule : awk_rc_model
`default_nettype wire

//--- bench/awk_wake_timer_tb.sv
/*
 * Self-checking bench of the auto wake-up timer.
 * Assumes the RC model stands in for the oscillator; bus per AXI4-Lite.
 */
`timescale 1ns/10ps
`default_nettype none
module awk_wake_timer_tb;
    import awk_pkg::*;
    localparam logic [11:0] CSR_A = {2'h0, AWK_CSR_IDX, 2'h0};
    localparam logic [11:0] PRE_A = {2'h0, AWK_PRE_IDX, 2'h0};
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    awk_axi_req_s req = '0;
    awk_axi_rsp_s rsp;
    logic hx = 1'b0, xirq = 1'b0, wen = 1'b0, wopt = 1'b0;
    logic tick, osc, hold, halted, awm, irq, imask, rcen, cap, wrst;
    logic res, vec;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [7:0] n;
    int miscompares = 0;
    int comparisons = 0;
    int ticks = 0;
    int cnt;

    always #10 mclk_i = ~mclk_i;

    awk_wake_timer dut_u (.mclk_i(mclk_i), .reset_i(reset_i),
        .axi_req_i(req), .axi_rsp_o(rsp), .halt_exec_i(hx),
        .halt_exit_irq_i(xirq), .watchdog_en_i(wen),
        .watchdog_in_halt_option_i(wopt), .rc_tick_i(tick),
        .main_osc_en_o(osc), .cpu_hold_o(hold), .halted_o(halted),
        .auto_wake_halt_mode_o(awm), .wake_irq_o(irq),
        .imask_clear_o(imask), .rc_osc_en_o(rcen), .rc_capture_o(cap),
        .watchdog_reset_o(wrst), .resume_o(res),
        .resume_wake_vector_o(vec));
    awk_rc_model rc_u (.mclk_i(mclk_i), .en_i(rcen), .tick_o(tick));

    task automatic give_verdict();
        $display("Comparisons %0d, miscompares %0d", comparisons,
            miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] x,
        input string what);
        comparisons++;
        if (got !== x) begin
            miscompares++;
            $display("ERROR at %0t: %s got %0h", $time, what, got);
        end
    endtask : chk

    // Responses checked against the oldest note
    always @(posedge mclk_i) begin
        if (rsp.bvalid || rsp.rvalid) begin
            e = exp_q.pop_front();
            chk({30'h0, rsp.bvalid ? rsp.bresp : rsp.rresp},
                {30'h0, e[33:32]}, "response code");
            if (rsp.rvalid) chk(rsp.rdata, e[31:0], "read data");
        end
    end

    // RC ticks seen while halted
    always @(posedge mclk_i) begin
        if (halted && tick) ticks++;
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] r);
        exp_q.push_back({r, 32'h0});
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        do begin
            @(posedge mclk_i);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] r);
        exp_q.push_back({r, d});
        req.arvalid <= 1'b1;
        req.araddr <= a;
        do begin
            @(posedge mclk_i);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
    endtask : rd

    task automatic do_halt();
        hx <= 1'b1;
        @(posedge mclk_i);
        hx <= 1'b0;
        @(negedge mclk_i);
    endtask : do_halt

    task automatic wait_wake();
        for (int i = 0; i < 3000 && halted; i++) @(negedge mclk_i);
    endtask : wait_wake

    task automatic stab(input logic v);
        cnt = 0;
        for (int i = 0; i < 600 && !res; i++) begin
            if (hold) cnt++;
            @(negedge mclk_i);
        end
        chk(32'(cnt), 32'd256, "stabilisation cycles");
        chk({31'h0, vec}, {31'h0, v}, "wake vector");
        chk({31'h0, osc}, 32'h1, "main oscillator on");
        @(posedge mclk_i);
    endtask : stab

    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        give_verdict();
    end

    initial begin
        req.bready <= 1'b1;
        req.rready <= 1'b1;
        void'($urandom(76));
        n = 8'($urandom_range(3, 1));
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
        rd(CSR_A, 32'h0, AWK_OKAY);
        rd(PRE_A, 32'hFF, AWK_OKAY);
        rd(12'h128, 32'h0, AWK_SLVERR);
        wr(PRE_A, 32'h0, AWK_OKAY);
        rd(PRE_A, 32'hFF, AWK_OKAY);
        wr(PRE_A, 32'(n), AWK_OKAY);
        rd(PRE_A, 32'(n), AWK_OKAY);
        wr(CSR_A, 32'h6, AWK_OKAY);
        rd(CSR_A, 32'h2, AWK_OKAY);
        chk({31'h0, cap}, 32'h1, "capture routing");
        chk({31'h0, rcen}, 32'h1, "RC enable");
        wr(CSR_A, 32'h1, AWK_OKAY);
        rd(CSR_A, 32'h1, AWK_OKAY);
        chk({31'h0, cap}, 32'h0, "capture off");
        wen <= 1'b1;
        do_halt();
        chk({31'h0, wrst}, 32'h1, "watchdog reset");
        chk({31'h0, halted}, 32'h0, "no halt");
        @(posedge mclk_i);
        wopt <= 1'b1;
        do_halt();
        chk({31'h0, halted}, 32'h1, "halted");
        chk({31'h0, awm}, 32'h1, "auto-wake mode");
        chk({31'h0, osc}, 32'h0, "oscillator off");
        chk({31'h0, imask}, 32'h1, "mask clear");
        chk({31'h0, wrst}, 32'h0, "no watchdog reset");
        repeat (20) @(posedge mclk_i);
        xirq <= 1'b1;
        wait_wake();
        stab(1'b0);
        do_halt();
        @(negedge mclk_i);
        chk({31'h0, halted}, 32'h0, "immediate wake");
        stab(1'b0);
        xirq <= 1'b0;
        ticks = 0;
        do_halt();
        wait_wake();
        chk(32'(ticks), 32'(64 * n), "halt length");
        stab(1'b1);
        chk({31'h0, irq}, 32'h1, "wake interrupt");
        rd(CSR_A, 32'h5, AWK_OKAY);
        rd(CSR_A, 32'h1, AWK_OKAY);
        chk({31'h0, irq}, 32'h0, "interrupt cleared");
        wr(CSR_A, 32'h0, AWK_OKAY);
        do_halt();
        chk({31'h0, halted}, 32'h1, "plain halt");
        chk({31'h0, awm}, 32'h0, "no auto-wake mode");
        chk({31'h0, rcen}, 32'h0, "RC off in plain halt");
        repeat (5) @(posedge mclk_i);
        xirq <= 1'b1;
        wait_wake();
        stab(1'b0);
        xirq <= 1'b0;
        give_verdict();
    end
endmodule : awk_wake_timer_tb
`default_nettype wire
